// [hdl/bol_pkg.sv]
// constants, types and decoders for the stage-zero brownout limiter bank
// Notes on behaviour
// - stage-one hold codes 1..6 timed, 7 unlimited, 0 no hold
// - unlimited hold ends only on hold clear or stage-one disable
// - stage-one disable: 0 enabled, 1 disabled, resets 0
// - dwell codes 0..7 give 0 to 8000 us
// - attack step 0.0625, 0.5+0.3958n, 6 dB
// - attack interval codes give 2.5 to 500 us
// - release step encoded like attack step
// - release interval codes give 5 to 1000 ms
// - max attenuation is 1 dB per code
// - threshold 0.05 V steps, base per rail
package bol_pkg;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int HALF_US_NS = 500;
  localparam int HALF_US_CYCLES = (HALF_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_US_PER_MS = 2000;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [7:0] OFS_S1_HOLD_DIS = 8'h2D;
  localparam logic [7:0] OFS_S0_DWELL_ATK = 8'h2E;
  localparam logic [7:0] OFS_S0_ATKRT_RLSST = 8'h2F;
  localparam logic [7:0] OFS_S0_RLSRT_MAX = 8'h30;
  localparam logic [7:0] OFS_S0_THRESHOLD = 8'h31;
  localparam logic [7:0] OFS_CTRL = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h39;

  localparam logic [7:0] RST_S1_HOLD_DIS = 8'h20;
  localparam logic [7:0] RST_S0_DWELL_ATK = 8'h02;
  localparam logic [7:0] RST_S0_ATKRT_RLSST = 8'h06;
  localparam logic [7:0] RST_S0_RLSRT_MAX = 8'h3E;
  localparam logic [7:0] RST_S0_THRESHOLD = 8'h37;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_S1_HOLD_DIS = 8'hF0;
  localparam logic [7:0] MASK_STEP_REG = 8'hFE;

  localparam int HOLD_LSB = 5;
  localparam int DIS_BIT = 4;
  localparam int SEL3_LSB = 5;
  localparam int STEP_LSB = 1;
  localparam int MAX_LSB = 0;
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_HCLR_BIT = 1;
  localparam int ST_BELOW_BIT = 0;
  localparam int ST_HOLD_BIT = 1;
  localparam int ST_LIMIT_BIT = 2;

  // ********************************************************
  // decode tables: dwell and attack in 0.5 us ticks, others in ms
  // ********************************************************
  localparam logic [2:0] HOLD_INFINITE = 3'h7;
  localparam logic [15:0] HOLD_MS [8] = '{16'h0000, 16'h000A, 16'h0064, 16'h00FA,
                                          16'h01F4, 16'h03E8, 16'h07D0, 16'h0000};
  localparam logic [15:0] DWELL_HUS [8] = '{16'h0000, 16'h00C8, 16'h01F4, 16'h03E8,
                                            16'h07D0, 16'h0FA0, 16'h1F40, 16'h3E80};
  localparam logic [15:0] ATK_HUS [8] = '{16'h0005, 16'h000A, 16'h0014, 16'h0032,
                                          16'h0064, 16'h00C8, 16'h01F4, 16'h03E8};
  localparam logic [15:0] RLS_MS [8] = '{16'h0005, 16'h000A, 16'h0019, 16'h0032,
                                         16'h0064, 16'h00FA, 16'h01F4, 16'h03E8};

  // gain figures in units of 0.0001 dB
  localparam logic [18:0] STEP_MIN_E4 = 19'h00271;
  localparam logic [18:0] STEP_BASE_E4 = 19'h01388;
  localparam logic [18:0] STEP_INC_E4 = 19'h00F76;
  localparam logic [18:0] STEP_MAX_E4 = 19'h0EA60;
  localparam logic [18:0] DB_E4 = 19'h02710;

  // thresholds in mV
  localparam logic [14:0] TH_BAT_BASE_MV = 15'h0A8C;
  localparam logic [14:0] TH_HV_BASE_MV = 15'h157C;
  localparam logic [14:0] TH_STEP_MV = 15'h0032;
  localparam logic [7:0] TH_BAT_MAX_CODE = 8'h38;

  typedef enum logic [1:0] {LIM_IDLE, LIM_DWELL, LIM_ATTACK, LIM_RELEASE} bol_lim_type;

  function automatic logic [18:0] bol_step_e4(input logic [3:0] code);
    logic [18:0] r;
    r = 19'(STEP_BASE_E4 + 19'(STEP_INC_E4 * 19'(code - 4'h1)));
    if (code == 4'h0) begin
      r = STEP_MIN_E4;
    end else if (code == 4'hF) begin
      r = STEP_MAX_E4;
    end
    return r;
  endfunction : bol_step_e4

endpackage : bol_pkg

// [hdl/bol_tick_gen.sv]
// half-microsecond and millisecond time base
`timescale 1ns/1ps
module bol_tick_gen
  import bol_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  output logic tick_half_us,
  output logic tick_ms
);
  logic [7:0] div_r;
  logic [11:0] ms_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r <= 8'h00;
      tick_half_us <= 1'b0;
    end else if (clk_en) begin
      tick_half_us <= (div_r == 8'(HALF_US_CYCLES - 1));
      div_r <= (div_r == 8'(HALF_US_CYCLES - 1)) ? 8'h00 : 8'(div_r + 8'h01);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ms_r <= 12'h000;
      tick_ms <= 1'b0;
    end else if (clk_en) begin
      tick_ms <= 1'b0;
      if (tick_half_us) begin
        tick_ms <= (ms_r == 12'(HALF_US_PER_MS - 1));
        ms_r <= (ms_r == 12'(HALF_US_PER_MS - 1)) ? 12'h000 : 12'(ms_r + 12'h001);
      end
    end
  end
endmodule : bol_tick_gen

// [hdl/bol_timer.sv]
// down-counting interval timer on a selectable time base
`timescale 1ns/1ps
module bol_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic tick_half_us,
  input wire logic tick_ms,
  bol_timer_if.tmr tif
);
  logic [15:0] cnt_r;
  logic busy_r;
  logic ms_r;
  logic done_r;
  logic tick;

  // the first tick may come early, so an interval can be up to one tick short
  assign tick = ms_r ? tick_ms : tick_half_us;
  assign tif.busy = busy_r;
  assign tif.done = done_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      busy_r <= 1'b0;
      ms_r <= 1'b0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      done_r <= 1'b0;
      if (tif.start) begin
        cnt_r <= tif.ticks;
        ms_r <= tif.use_ms;
        busy_r <= (tif.ticks != 16'h0000);
        done_r <= (tif.ticks == 16'h0000);
      end else if (busy_r && tick) begin
        cnt_r <= 16'(cnt_r - 16'h0001);
        if (cnt_r == 16'h0001) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule : bol_timer

// [hdl/bol_timer_if.sv]
// request and completion signals between the limiter and an interval timer
`timescale 1ns/1ps
interface bol_timer_if;
  logic start;
  logic [15:0] ticks;
  logic use_ms;
  logic done;
  logic busy;
  modport ctrl (output start, output ticks, output use_ms, input done, input busy);
  modport tmr (input start, input ticks, input use_ms, output done, output busy);
endinterface : bol_timer_if

// [hdl/bol_top.sv]
// stage-zero brownout limiter: register bank, gain stepping and stage-one hold
`timescale 1ns/1ps
module bol_top
  import bol_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [14:0] battery_rail_mv,
  input wire logic [14:0] high_voltage_rail_mv,
  input wire logic stage1_attack,
  output logic [18:0] gain_atten_e4,
  output logic stage1_hold_active
);
  import bol_pkg::*;

  // ********************************************************
  // register bank
  // ********************************************************
  logic [7:0] s1_hold_dis_r;
  logic [7:0] s0_dwell_atk_r;
  logic [7:0] s0_atkrt_rlsst_r;
  logic [7:0] s0_rlsrt_max_r;
  logic [7:0] s0_threshold_r;
  logic [7:0] ctrl_r;
  logic hold_clear_r;
  logic [7:0] rdata_r;
  logic [7:0] status;

  logic [2:0] stage1_hold_time_sel;
  logic stage1_disable;
  logic [2:0] stage0_dwell_time_sel;
  logic [3:0] stage0_attack_step_sel;
  logic [2:0] stage0_attack_rate_sel;
  logic [3:0] stage0_release_step_sel;
  logic [2:0] stage0_release_rate_sel;
  logic [4:0] stage0_max_attenuation;
  logic [7:0] stage0_threshold_code;
  logic monitored_supply_select;

  assign stage1_hold_time_sel = s1_hold_dis_r[HOLD_LSB +: 3];
  assign stage1_disable = s1_hold_dis_r[DIS_BIT];
  assign stage0_dwell_time_sel = s0_dwell_atk_r[SEL3_LSB +: 3];
  assign stage0_attack_step_sel = s0_dwell_atk_r[STEP_LSB +: 4];
  assign stage0_attack_rate_sel = s0_atkrt_rlsst_r[SEL3_LSB +: 3];
  assign stage0_release_step_sel = s0_atkrt_rlsst_r[STEP_LSB +: 4];
  assign stage0_release_rate_sel = s0_rlsrt_max_r[SEL3_LSB +: 3];
  assign stage0_max_attenuation = s0_rlsrt_max_r[MAX_LSB +: 5];
  assign stage0_threshold_code = s0_threshold_r;
  assign monitored_supply_select = ctrl_r[CTRL_SRC_BIT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_hold_dis_r <= RST_S1_HOLD_DIS;
      s0_dwell_atk_r <= RST_S0_DWELL_ATK;
      s0_atkrt_rlsst_r <= RST_S0_ATKRT_RLSST;
      s0_rlsrt_max_r <= RST_S0_RLSRT_MAX;
      s0_threshold_r <= RST_S0_THRESHOLD;
      ctrl_r <= RST_CTRL;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        OFS_S1_HOLD_DIS: s1_hold_dis_r <= reg_wdata & MASK_S1_HOLD_DIS;
        OFS_S0_DWELL_ATK: s0_dwell_atk_r <= reg_wdata & MASK_STEP_REG;
        OFS_S0_ATKRT_RLSST: s0_atkrt_rlsst_r <= reg_wdata & MASK_STEP_REG;
        OFS_S0_RLSRT_MAX: s0_rlsrt_max_r <= reg_wdata;
        OFS_S0_THRESHOLD: s0_threshold_r <= reg_wdata;
        OFS_CTRL: ctrl_r <= {7'h00, reg_wdata[CTRL_SRC_BIT]};
        default: ;
      endcase
    end
  end

  // hold clear is a write-one pulse and never reads back as set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_clear_r <= 1'b0;
    end else if (clk_en) begin
      hold_clear_r <= reg_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_HCLR_BIT];
    end
  end

  // read data stands for one cycle only; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      rdata_r <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          OFS_S1_HOLD_DIS: rdata_r <= s1_hold_dis_r;
          OFS_S0_DWELL_ATK: rdata_r <= s0_dwell_atk_r;
          OFS_S0_ATKRT_RLSST: rdata_r <= s0_atkrt_rlsst_r;
          OFS_S0_RLSRT_MAX: rdata_r <= s0_rlsrt_max_r;
          OFS_S0_THRESHOLD: rdata_r <= s0_threshold_r;
          OFS_CTRL: rdata_r <= ctrl_r;
          OFS_STATUS: rdata_r <= status;
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_r;

  // ********************************************************
  // time base and timers
  // ********************************************************
  logic tick_half_us;
  logic tick_ms;
  bol_timer_if lim_if ();
  bol_timer_if hold_if ();

  bol_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .tick_half_us(tick_half_us),
    .tick_ms(tick_ms)
  );

  bol_timer u_lim_tmr (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .tick_half_us(tick_half_us),
    .tick_ms(tick_ms),
    .tif(lim_if.tmr)
  );

  bol_timer u_hold_tmr (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .tick_half_us(tick_half_us),
    .tick_ms(tick_ms),
    .tif(hold_if.tmr)
  );

  // ********************************************************
  // threshold compare
  // ********************************************************
  logic [7:0] th_code;
  logic [14:0] threshold_mv;
  logic [14:0] supply_mv;
  logic below_r;

  // reserved battery codes are held at the top of the battery range
  always_comb begin
    th_code = stage0_threshold_code;
    if (!monitored_supply_select && th_code > TH_BAT_MAX_CODE) begin
      th_code = TH_BAT_MAX_CODE;
    end
    threshold_mv = 15'((monitored_supply_select ? TH_HV_BASE_MV : TH_BAT_BASE_MV)
                   + 15'(TH_STEP_MV * 15'(th_code)));
    supply_mv = monitored_supply_select ? high_voltage_rail_mv : battery_rail_mv;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      below_r <= 1'b0;
    end else if (clk_en) begin
      below_r <= supply_mv < threshold_mv;
    end
  end

  // ********************************************************
  // gain stepping
  // ********************************************************
  bol_lim_type state_r;
  logic [18:0] atten_r;
  logic [18:0] max_e4;
  logic [18:0] atk_e4;
  logic [18:0] rls_e4;
  logic [19:0] sum;
  logic [18:0] add_sat;
  logic [18:0] sub_sat;
  logic step_up;
  logic step_down;
  logic lim_start_r;
  logic [15:0] lim_ticks_r;
  logic lim_ms_r;

  assign max_e4 = 19'(DB_E4 * 19'(stage0_max_attenuation));
  assign atk_e4 = bol_step_e4(stage0_attack_step_sel);
  assign rls_e4 = bol_step_e4(stage0_release_step_sel);
  assign sum = {1'b0, atten_r} + {1'b0, atk_e4};
  assign add_sat = (sum > {1'b0, max_e4}) ? max_e4 : sum[18:0];
  assign sub_sat = (atten_r > rls_e4) ? ((19'(atten_r - rls_e4) > max_e4) ? max_e4
                   : 19'(atten_r - rls_e4)) : 19'h00000;
  assign step_up = lim_if.done && below_r
                   && (state_r == LIM_DWELL || state_r == LIM_ATTACK);
  assign step_down = lim_if.done && (state_r == LIM_RELEASE) && !below_r;

  assign lim_if.start = lim_start_r;
  assign lim_if.ticks = lim_ticks_r;
  assign lim_if.use_ms = lim_ms_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      atten_r <= 19'h00000;
    end else if (clk_en) begin
      if (step_up) begin
        atten_r <= add_sat;
      end else if (step_down) begin
        atten_r <= sub_sat;
      end else if (atten_r > max_e4) begin
        atten_r <= max_e4;
      end
    end
  end

  // a supply dip during release goes straight back to attack, skipping dwell
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= LIM_IDLE;
      lim_start_r <= 1'b0;
      lim_ticks_r <= 16'h0000;
      lim_ms_r <= 1'b0;
    end else if (clk_en) begin
      lim_start_r <= 1'b0;
      case (state_r)
        LIM_IDLE: begin
          if (below_r) begin
            state_r <= LIM_DWELL;
            lim_start_r <= 1'b1;
            lim_ticks_r <= DWELL_HUS[stage0_dwell_time_sel];
            lim_ms_r <= 1'b0;
          end
        end
        LIM_DWELL: begin
          if (!below_r) begin
            state_r <= LIM_IDLE;
          end else if (lim_if.done) begin
            state_r <= LIM_ATTACK;
            lim_start_r <= 1'b1;
            lim_ticks_r <= ATK_HUS[stage0_attack_rate_sel];
            lim_ms_r <= 1'b0;
          end
        end
        LIM_ATTACK: begin
          if (lim_if.done) begin
            lim_start_r <= 1'b1;
            if (below_r) begin
              lim_ticks_r <= ATK_HUS[stage0_attack_rate_sel];
              lim_ms_r <= 1'b0;
            end else begin
              state_r <= LIM_RELEASE;
              lim_ticks_r <= RLS_MS[stage0_release_rate_sel];
              lim_ms_r <= 1'b1;
            end
          end
        end
        LIM_RELEASE: begin
          if (below_r) begin
            state_r <= LIM_ATTACK;
            lim_start_r <= 1'b1;
            lim_ticks_r <= ATK_HUS[stage0_attack_rate_sel];
            lim_ms_r <= 1'b0;
          end else if (lim_if.done) begin
            if (sub_sat == 19'h00000) begin
              state_r <= LIM_IDLE;
            end else begin
              lim_start_r <= 1'b1;
              lim_ticks_r <= RLS_MS[stage0_release_rate_sel];
              lim_ms_r <= 1'b1;
            end
          end
        end
        default: state_r <= LIM_IDLE;
      endcase
    end
  end

  assign gain_atten_e4 = atten_r;

  // ********************************************************
  // stage-one hold
  // ********************************************************
  logic hold_active_r;
  logic hold_go;

  assign hold_go = stage1_attack && !stage1_disable && (stage1_hold_time_sel != 3'h0);
  assign hold_if.start = clk_en && hold_go && (stage1_hold_time_sel != HOLD_INFINITE);
  assign hold_if.ticks = HOLD_MS[stage1_hold_time_sel];
  assign hold_if.use_ms = 1'b1;

  // a new attack in the same cycle as a hold clear wins and restarts the hold
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_active_r <= 1'b0;
    end else if (clk_en) begin
      if (stage1_disable) begin
        hold_active_r <= 1'b0;
      end else if (hold_go) begin
        hold_active_r <= 1'b1;
      end else if (hold_clear_r) begin
        hold_active_r <= 1'b0;
      end else if (hold_if.done && stage1_hold_time_sel != HOLD_INFINITE) begin
        hold_active_r <= 1'b0;
      end
    end
  end

  assign stage1_hold_active = hold_active_r;

  assign status = {5'h00, 1'b0, 1'b0, 1'b0}
                  | (8'(atten_r != 19'h00000) << ST_LIMIT_BIT)
                  | (8'(hold_active_r) << ST_HOLD_BIT)
                  | (8'(below_r) << ST_BELOW_BIT);

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  hold_unlimited_a: assert property (
    clk_en && hold_active_r && stage1_hold_time_sel == HOLD_INFINITE && !stage1_disable
    && !hold_clear_r |=> hold_active_r)
    else $error("unlimited hold dropped without hold clear");

  hold_start_a: assert property (
    clk_en && stage1_attack && !stage1_disable
    |=> hold_active_r == ($past(stage1_hold_time_sel) != 3'h0))
    else $error("hold start does not follow hold code");

  disable_kills_a: assert property (
    clk_en && stage1_disable |=> !hold_active_r)
    else $error("disabled stage one still holds");

  dwell_load_a: assert property (
    clk_en && state_r == LIM_IDLE && below_r |=> lim_start_r && !lim_ms_r
    && lim_ticks_r == DWELL_HUS[$past(stage0_dwell_time_sel)])
    else $error("dwell interval not loaded");

  attack_step_a: assert property (
    clk_en && step_up |=> atten_r == $past(add_sat) && atten_r <= $past(max_e4))
    else $error("attack step wrong");

  attack_rate_a: assert property (
    clk_en && state_r == LIM_ATTACK && lim_if.done && below_r |=> lim_start_r
    ##0 lim_ticks_r == ATK_HUS[$past(stage0_attack_rate_sel)])
    else $error("attack interval not reloaded");

  release_step_a: assert property (
    clk_en && step_down |=> atten_r < $past(atten_r) || atten_r == 19'h00000)
    else $error("release did not lower attenuation");

  release_rate_a: assert property (
    clk_en && state_r == LIM_ATTACK && lim_if.done && !below_r |=> state_r == LIM_RELEASE
    && lim_ms_r && lim_ticks_r == RLS_MS[$past(stage0_release_rate_sel)])
    else $error("release interval not loaded");

  max_atten_a: assert property (
    clk_en && atten_r > max_e4 |=> atten_r <= $past(max_e4) || $past(step_up))
    else $error("attenuation above the maximum");

  battery_range_a: assert property (
    !monitored_supply_select |-> threshold_mv <= 15'((TH_BAT_BASE_MV
    + 15'(TH_STEP_MV * 15'(TH_BAT_MAX_CODE)))))
    else $error("battery threshold above range");

  idle_clear_a: assert property (
    state_r == LIM_IDLE && !below_r |-> atten_r == 19'h00000 || $past(state_r) != LIM_IDLE)
    else $error("idle with attenuation left");

endmodule : bol_top

// [tb/tb_bol_top.sv]
// self-checking bench for the stage-zero brownout limiter bank
`timescale 1ns/1ps
module tb_bol_top;
  import bol_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [14:0] battery_rail_mv = 15'h1770;
  logic [14:0] high_voltage_rail_mv = 15'h2EE0;
  logic stage1_attack = 1'b0;
  logic [18:0] gain_atten_e4;
  logic stage1_hold_active;
  int err_total = 0;
  int samples_checked = 0;
  logic [7:0] d;
  logic [18:0] acc;
  logic [14:0] mv;
  int n;
  localparam logic [7:0] OFS [6] = '{8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h38};
  localparam logic [7:0] RSTV [6] = '{8'h20, 8'h02, 8'h06, 8'h3E, 8'h37, 8'h00};
  localparam logic [7:0] WMSK [6] = '{8'hF0, 8'hFE, 8'hFE, 8'hFF, 8'hFF, 8'h01};
  localparam logic [7:0] TCODE [8] = '{8'h00, 8'h00, 8'h38, 8'h40, 8'h40, 8'h00, 8'hFF, 8'hFF};
  localparam logic TSRC [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic [14:0] TOFS [8] = '{15'h0, 15'h1, 15'h1, 15'h0, 15'h1, 15'h1, 15'h0, 15'h1};
  localparam logic [3:0] SCODE [3] = '{4'hF, 4'h0, 4'hE};

  always #2 sys_clk = ~sys_clk;

  bol_top dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .battery_rail_mv(battery_rail_mv), .high_voltage_rail_mv(high_voltage_rail_mv),
    .stage1_attack(stage1_attack), .gain_atten_e4(gain_atten_e4),
    .stage1_hold_active(stage1_hold_active));

  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk19(input string nm, input logic [18:0] e, input logic [18:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk19

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // bus and stimulus
  // ****************************************
  task automatic do_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic attack_pulse();
    @(posedge sys_clk);
    stage1_attack <= 1'b1;
    @(posedge sys_clk);
    stage1_attack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : attack_pulse

  task automatic reg_sweep(input logic fill);
    logic [7:0] v;
    for (int i = 0; i < 6; i++) begin
      if (fill) begin
        wr(OFS[i], 8'hFF);
      end
      rd(OFS[i], v);
      chk8("register", fill ? WMSK[i] : RSTV[i], v);
    end
  endtask : reg_sweep

  // bounded wait for the attenuation to move; counts cycles
  task automatic wait_step(output int cyc);
    logic [18:0] p;
    p = gain_atten_e4;
    cyc = 0;
    while (gain_atten_e4 === p) begin
      @(posedge sys_clk);
      #1 cyc++;
      if (cyc > 1000) begin
        err_total++;
        $display("ERROR gain step expected change seen none");
        close_out();
      end
    end
  endtask : wait_step

  function automatic logic [18:0] step_e4(input logic [3:0] c);
    if (c == 4'h0) return 19'h00271;
    if (c == 4'hF) return 19'h0EA60;
    return 19'(19'h01388 + 19'h00F76 * 19'(c - 4'h1));
  endfunction : step_e4

  // reserved battery codes behave as the top battery code
  function automatic logic [14:0] th_mv(input logic s, input logic [7:0] c);
    logic [7:0] k;
    k = (!s && c > 8'h38) ? 8'h38 : c;
    return 15'((s ? 15'h157C : 15'h0A8C) + 15'h0032 * 15'(k));
  endfunction : th_mv

  // ****************************************
  // tests
  // ****************************************
  initial begin
    do_reset();
    reg_sweep(1'b0);
    reg_sweep(1'b1);
    wr(8'h3A, 8'hFF);
    rd(8'h3A, d);
    chk8("unmapped", 8'h00, d);
    do_reset();
    reg_sweep(1'b0);
    // a write while the clock enable is low must not land
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h31, 8'hAA);
    clk_en <= 1'b1;
    rd(8'h31, d);
    chk8("frozen write", 8'h37, d);
    $display("test registers done");

    wr(8'h2D, 8'hE0);
    attack_pulse();
    chk8("hold set", 8'h01, {7'h00, stage1_hold_active});
    repeat (200) @(posedge sys_clk);
    #1 chk8("hold kept", 8'h01, {7'h00, stage1_hold_active});
    wr(8'h38, 8'h02);
    repeat (3) @(posedge sys_clk);
    #1 chk8("hold cleared", 8'h00, {7'h00, stage1_hold_active});
    rd(8'h38, d);
    chk8("ctrl", 8'h00, d);
    wr(8'h2D, 8'hF0);
    attack_pulse();
    chk8("hold disabled", 8'h00, {7'h00, stage1_hold_active});
    wr(8'h2D, 8'h00);
    attack_pulse();
    chk8("hold code zero", 8'h00, {7'h00, stage1_hold_active});
    $display("test hold done");

    // zero max attenuation keeps the status byte down to the compare bit
    wr(8'h30, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h38, {7'h00, TSRC[i]});
      wr(8'h31, TCODE[i]);
      mv = th_mv(TSRC[i], TCODE[i]) - TOFS[i];
      @(posedge sys_clk);
      battery_rail_mv <= TSRC[i] ? 15'h0000 : mv;
      high_voltage_rail_mv <= TSRC[i] ? mv : 15'h0000;
      repeat (4) @(posedge sys_clk);
      rd(8'h39, d);
      chk8("below", {7'h00, TOFS[i] != 15'h0}, d);
    end
    $display("test threshold done");

    wr(8'h38, 8'h00);
    wr(8'h31, 8'h10);
    wr(8'h2E, 8'h02);
    wr(8'h2F, 8'h06);
    wr(8'h30, 8'h01);
    @(posedge sys_clk);
    battery_rail_mv <= th_mv(1'b0, 8'h10) - 15'h0001;
    wait_step(n);
    chk19("first step", step_e4(4'h1), gain_atten_e4);
    wait_step(n);
    chk19("second step", 19'h02710, gain_atten_e4);
    chk8("interval", 8'h01, {7'h00, n >= 500 && n <= 640});
    repeat (1500) @(posedge sys_clk);
    #1 chk19("clamp", 19'h02710, gain_atten_e4);
    acc = 19'h02710;
    wr(8'h2E, {3'h0, SCODE[0], 1'b0});
    wr(8'h30, 8'h1F);
    for (int i = 0; i < 3; i++) begin
      if (i > 0) begin
        wr(8'h2E, {3'h0, SCODE[i], 1'b0});
      end
      wait_step(n);
      acc = acc + step_e4(SCODE[i]);
      chk19("step size", acc, gain_atten_e4);
    end
    $display("test limiter done");
    close_out();
  end
endmodule : tb_bol_top
